// ### dv/pos_host_model.sv
// host board model: pull-ups, idle id bus, status synchronisers
`timescale 1ns/1ps
`default_nettype none
module pos_host_model (
    input  wire logic clk_i,
    input  wire logic fault_d_i,
    input  wire logic fault_oe_n_i,
    input  wire logic loss_d_i,
    input  wire logic loss_oe_n_i,
    input  wire logic present_d_i,
    input  wire logic present_oe_n_i,
    input  wire logic id_data_d_i,
    input  wire logic id_data_oe_n_i,
    input  wire logic id_clk_low_i,
    input  wire logic id_data_low_i,
    output logic      fault_w_o,
    output logic      loss_w_o,
    output logic      present_w_o,
    output logic      id_clk_w_o,
    output logic      id_data_w_o,
    output logic      fault_s_o,
    output logic      loss_s_o
);
    logic [1:0] fault_r;
    logic [1:0] loss_r;
    // ----------------------------------------
    // wire resolution
    // ----------------------------------------
    // pull-up wins unless the module pulls low
    assign fault_w_o   = fault_oe_n_i ? 1'h1 : fault_d_i;
    assign loss_w_o    = loss_oe_n_i ? 1'h1 : loss_d_i;
    assign present_w_o = present_oe_n_i ? 1'h1 : present_d_i;
    // host pulls data low as well; wired-and with the module
    assign id_data_w_o = (id_data_oe_n_i ? 1'h1 : id_data_d_i) && !id_data_low_i;
    // id clock high unless the bench pulls it, paced at the limit
    assign id_clk_w_o  = !id_clk_low_i;
    // ----------------------------------------
    // two-stage synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        fault_r <= {fault_r[0], fault_w_o};
        loss_r  <= {loss_r[0], loss_w_o};
    end
    assign fault_s_o = fault_r[1];
    assign loss_s_o  = loss_r[1];
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the sideband control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pos_pkg::*;
    localparam int unsigned INIT_N = 100;
    localparam int unsigned RST_N  = 20;
    // quarter period of the fastest legal id clock
    localparam int unsigned ID_Q   = CLK_MHZ * 1000 / ID_CLK_MAX_KHZ / 4;
    typedef struct {
        logic dis; logic low; logic rxd; int cyc; logic laser; logic absent; logic rxo;
    } pos_row_t;
    logic clk, rst, dis, flt, low, rxd, id_o, id_oe_n, laser, f_o, f_oe_n;
    logic l_o, l_oe_n, rx_o, p_o, p_oe_n, f_w, l_w, p_w, idc_w, idd_w, f_s, l_s;
    logic scl_low, sda_low, id_ack;
    logic [7:0] id_got;
    int   bad_count;
    int   compares;
    int   n;
    pos_row_t rows [5] = '{
        '{1'h0, 1'h0, 1'h1, 10, 1'h1, 1'h0, 1'h1},
        '{1'h1, 1'h0, 1'h1, 4,  1'h0, 1'h0, 1'h1},
        '{1'h0, 1'h0, 1'h0, 14, 1'h1, 1'h0, 1'h0},
        '{1'h0, 1'h1, 1'h1, 45, 1'h1, 1'h1, 1'h0},
        '{1'h0, 1'h0, 1'h1, 45, 1'h1, 1'h0, 1'h1}};
    pos_sideband #(.ON_CYCLES(10), .INIT_CYCLES(INIT_N), .LOSS_CYCLES(40),
        .RST_CYCLES(RST_N)) uut (
        .SYS_CLK_I(clk), .RST_I(rst), .TX_DISABLE_I(dis), .LASER_FAULT_I(flt),
        .RX_POWER_LOW_I(low), .RX_DATA_I(rxd), .ID_SERIAL_CLOCK_I(idc_w),
        .ID_SERIAL_DATA_I(idd_w), .ID_SERIAL_DATA_O(id_o),
        .ID_SERIAL_DATA_OE_N_O(id_oe_n), .LASER_ON_O(laser), .TX_FAULT_O(f_o),
        .TX_FAULT_OE_N_O(f_oe_n), .RX_SIGNAL_ABSENT_O(l_o),
        .RX_SIGNAL_ABSENT_OE_N_O(l_oe_n), .RX_DATA_O(rx_o),
        .MODULE_PRESENT_N_O(p_o), .MODULE_PRESENT_N_OE_N_O(p_oe_n));
    pos_host_model host (
        .clk_i(clk), .fault_d_i(f_o), .fault_oe_n_i(f_oe_n), .loss_d_i(l_o),
        .loss_oe_n_i(l_oe_n), .present_d_i(p_o), .present_oe_n_i(p_oe_n),
        .id_data_d_i(id_o), .id_data_oe_n_i(id_oe_n), .id_clk_low_i(scl_low),
        .id_data_low_i(sda_low), .fault_w_o(f_w), .loss_w_o(l_w), .present_w_o(p_w),
        .id_clk_w_o(idc_w), .id_data_w_o(idd_w), .fault_s_o(f_s), .loss_s_o(l_s));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic wait_laser(input int limit);
        for (n = 0; n < limit && laser !== 1'h1; n++) @(negedge clk);
    endtask
    // one id clock: data set in the low phase, line sampled mid high phase
    task automatic id_bit(input logic b, output logic seen);
        sda_low = !b;
        repeat (ID_Q) @(negedge clk);
        scl_low = 1'h0;
        repeat (ID_Q) @(negedge clk);
        seen = idd_w;
        repeat (ID_Q) @(negedge clk);
        scl_low = 1'h1;
        repeat (ID_Q) @(negedge clk);
    endtask
    task automatic id_byte(input logic [7:0] v, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) begin
            id_bit(v[i], got[i]);
        end
    endtask
    task automatic id_start();
        sda_low = 1'h1;
        repeat (ID_Q) @(negedge clk);
        scl_low = 1'h1;
        repeat (ID_Q) @(negedge clk);
    endtask
    task automatic id_stop();
        sda_low = 1'h1;
        repeat (ID_Q) @(negedge clk);
        scl_low = 1'h0;
        repeat (ID_Q) @(negedge clk);
        sda_low = 1'h0;
        repeat (ID_Q) @(negedge clk);
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        #320000;
        bad_count++;
        complete_run();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        bad_count = 0;
        compares = 0;
        {rst, dis, flt, low, rxd} = 5'h11;
        {scl_low, sda_low} = 2'h0;
        repeat (3) @(negedge clk);
        chk("laser_in_reset", laser, 1'h0);
        chk("absent_in_reset", l_w, 1'h1);
        chk("rx_data_in_reset", rx_o, 1'h0);
        chk("present_wire", p_w, 1'h0);
        chk("id_data_idle", idd_w, 1'h1);
        rst = 1'h0;
        wait_laser(INIT_N + 20);
        chk("laser_after_init", laser, 1'h1);
        chk("fault_wire_normal", f_w, 1'h0);
        foreach (rows[i]) begin
            {dis, low, rxd} = {rows[i].dis, rows[i].low, rows[i].rxd};
            repeat (rows[i].cyc) @(negedge clk);
            chk("laser", laser, rows[i].laser);
            chk("absent", l_w, rows[i].absent);
            chk("rx_data", rx_o, rows[i].rxo);
        end
        chk("absent_synced", l_s, 1'h0);
        flt = 1'h1;
        repeat (8) @(negedge clk);
        chk("fault_raised", f_w, 1'h1);
        flt = 1'h0;
        repeat (3) @(negedge clk);
        chk("fault_synced", f_s, 1'h1);
        // too short a disable pulse leaves the fault latched
        dis = 1'h1;
        repeat (RST_N / 2) @(negedge clk);
        dis = 1'h0;
        repeat (10) @(negedge clk);
        chk("fault_kept", f_w, 1'h1);
        dis = 1'h1;
        repeat (RST_N + 5) @(negedge clk);
        dis = 1'h0;
        repeat (5) @(negedge clk);
        wait_laser(INIT_N + 40);
        chk("laser_after_clear", laser, 1'h1);
        chk("fault_cleared", f_w, 1'h0);
        // reset in mid-run returns to the power-on state
        rst = 1'h1;
        repeat (3) @(negedge clk);
        chk("laser_mid_reset", laser, 1'h0);
        chk("absent_mid_reset", l_w, 1'h1);
        chk("rx_data_mid_reset", rx_o, 1'h0);
        chk("fault_mid_reset", f_w, 1'h0);
        rst = 1'h0;
        repeat (2) @(negedge clk);
        chk("laser_held_in_init", laser, 1'h0);
        wait_laser(INIT_N + 20);
        chk("laser_after_reset", laser, 1'h1);
        // id read at the clock limit, then a foreign address
        id_start();
        id_byte({ID_DEV_ADDR, 1'h1}, id_got);
        id_bit(1'h1, id_ack);
        chk("id_ack", id_ack, 1'h0);
        id_byte(8'hff, id_got);
        for (int i = 0; i < 8; i++) begin
            chk("id_data_bit", id_got[i], ID_ROM_FILL[i]);
        end
        id_bit(1'h1, id_ack);
        id_stop();
        chk("id_released", idd_w, 1'h1);
        id_start();
        id_byte({ID_DEV_ADDR ^ 7'h01, 1'h1}, id_got);
        id_bit(1'h1, id_ack);
        chk("id_foreign_nack", id_ack, 1'h1);
        id_stop();
        chk("id_idle_after", idd_w, 1'h1);
        complete_run();
    end
endmodule
`default_nettype wire

// ### hw/pos_pkg.sv
// constants for the pluggable optic sideband control block
package pos_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned T_OFF_US         = 10;
    localparam int unsigned T_ON_MS          = 1;
    localparam int unsigned T_INIT_MS        = 300;
    localparam int unsigned T_FAULT_US       = 100;
    localparam int unsigned T_RESET_US       = 10;
    localparam int unsigned T_LOSS_US        = 100;
    localparam int unsigned OFF_CYC          = T_OFF_US * CLK_MHZ;
    localparam int unsigned ON_CYC           = T_ON_MS * 1000 * CLK_MHZ;
    localparam int unsigned INIT_CYC         = T_INIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned FAULT_CYC        = T_FAULT_US * CLK_MHZ;
    localparam int unsigned RESET_HOLD_CYC   = T_RESET_US * CLK_MHZ;
    localparam int unsigned LOSS_CYC         = T_LOSS_US * CLK_MHZ;
    localparam logic [6:0]  ID_DEV_ADDR      = 7'h50;
    localparam int unsigned ID_CLK_MAX_KHZ   = 100;
    localparam logic [7:0]  ID_ROM_FILL      = 8'h00;

    typedef enum logic [3:0] {
        ST_INIT  = 4'b0001,
        ST_OFF   = 4'b0010,
        ST_ON    = 4'b0100,
        ST_FAULT = 4'b1000
    } pos_state_t;

    typedef enum logic [4:0] {
        IS_IDLE = 5'b00001,
        IS_ADDR = 5'b00010,
        IS_ACK  = 5'b00100,
        IS_RD   = 5'b01000,
        IS_RACK = 5'b10000
    } pos_id_t;
endpackage

// ### hw/pos_sideband.sv
// sideband control: laser enable, fault, signal loss, presence, id two-wire slave
`timescale 1ns/1ps
`default_nettype none

module pos_sideband
    import pos_pkg::*;
#(
    parameter int unsigned ON_CYCLES   = ON_CYC,
    parameter int unsigned INIT_CYCLES = INIT_CYC,
    parameter int unsigned LOSS_CYCLES = LOSS_CYC,
    parameter int unsigned RST_CYCLES  = RESET_HOLD_CYC
) (
    input  wire logic SYS_CLK_I,
    input  wire logic RST_I,
    input  wire logic TX_DISABLE_I,
    input  wire logic LASER_FAULT_I,
    input  wire logic RX_POWER_LOW_I,
    input  wire logic RX_DATA_I,
    input  wire logic ID_SERIAL_CLOCK_I,
    input  wire logic ID_SERIAL_DATA_I,
    output logic      ID_SERIAL_DATA_O,
    output logic      ID_SERIAL_DATA_OE_N_O,
    output logic      LASER_ON_O,
    output logic      TX_FAULT_O,
    output logic      TX_FAULT_OE_N_O,
    output logic      RX_SIGNAL_ABSENT_O,
    output logic      RX_SIGNAL_ABSENT_OE_N_O,
    output logic      RX_DATA_O,
    output logic      MODULE_PRESENT_N_O,
    output logic      MODULE_PRESENT_N_OE_N_O
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // unconnected disable reads high: pull-up modelled by reset value
    logic [1:0] dis_s_r, flt_s_r, pwr_s_r, scl_s_r, sda_s_r, rxd_s_r;
    logic       scl_d_r, sda_d_r;
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            dis_s_r <= 2'h3;
            flt_s_r <= 2'h0;
            pwr_s_r <= 2'h3;
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            rxd_s_r <= 2'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            dis_s_r <= {dis_s_r[0], TX_DISABLE_I};
            flt_s_r <= {flt_s_r[0], LASER_FAULT_I};
            pwr_s_r <= {pwr_s_r[0], RX_POWER_LOW_I};
            scl_s_r <= {scl_s_r[0], ID_SERIAL_CLOCK_I};
            sda_s_r <= {sda_s_r[0], ID_SERIAL_DATA_I};
            rxd_s_r <= {rxd_s_r[0], RX_DATA_I};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    wire dis  = dis_s_r[1];
    wire flt  = flt_s_r[1];
    wire pwr_low = pwr_s_r[1];
    wire scl  = scl_s_r[1];
    wire sda  = sda_s_r[1];

    // ------------------------------------------------------------
    // transmitter state machine
    // ------------------------------------------------------------
    pos_state_t st_r, st_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [31:0] hold_r;
    logic        laser_r, fault_r;

    wire dis_held  = (hold_r >= RST_CYCLES);
    wire init_done = (tmr_r >= INIT_CYCLES - 1);
    wire on_done   = (tmr_r >= ON_CYCLES - 1);

    function automatic logic [31:0] inc32(input logic [31:0] v);
        return v + 32'h0000_0001;
    endfunction

    always_comb begin
        st_nxt  = st_r;
        tmr_nxt = inc32(tmr_r);
        unique case (st_r)
            ST_INIT: begin
                if (init_done) begin
                    st_nxt  = dis ? ST_OFF : ST_ON;
                    tmr_nxt = 32'h0000_0000;
                end
            end
            ST_OFF: begin
                tmr_nxt = 32'h0000_0000;
                if (!dis)
                    st_nxt = ST_ON;
            end
            ST_ON: begin
                if (dis) begin
                    st_nxt  = ST_OFF;
                    tmr_nxt = 32'h0000_0000;
                end else if (flt) begin
                    st_nxt  = ST_FAULT;
                end else if (!on_done) begin
                    tmr_nxt = inc32(tmr_r);
                end else begin
                    tmr_nxt = tmr_r;
                end
            end
            ST_FAULT: begin
                tmr_nxt = 32'h0000_0000;
                if (!dis && dis_held)
                    st_nxt = ST_INIT;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_r    <= ST_INIT;
            tmr_r   <= 32'h0000_0000;
            hold_r  <= 32'h0000_0000;
            laser_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            tmr_r   <= tmr_nxt;
            hold_r  <= dis ? (dis_held ? hold_r : inc32(hold_r)) : 32'h0000_0000;
            laser_r <= (st_nxt == ST_ON) && !dis;
            fault_r <= (st_nxt == ST_FAULT);
        end
    end

    assign LASER_ON_O      = laser_r;
    // open-drain: low drive while enable low
    assign TX_FAULT_O      = 1'b0;
    assign TX_FAULT_OE_N_O = fault_r;

    a_laser_off_fast: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(dis) |-> ##[1:2] !LASER_ON_O)
        else $error("laser still on after disable");
    a_fault_flag_sets: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (st_r == ST_ON && !dis && flt) |=> ##1 !TX_FAULT_OE_N_O == 1'b0)
        else $error("fault not reported");
    a_laser_follows_dis: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        dis |=> !LASER_ON_O)
        else $error("laser on while disabled");
    a_fault_no_laser: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        TX_FAULT_OE_N_O |-> !LASER_ON_O)
        else $error("laser on during fault");
    a_fault_clear: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (st_r == ST_FAULT && !dis && dis_held) |=> st_r == ST_INIT)
        else $error("fault reset not taken");
    a_laser_on_fast: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (st_r == ST_OFF && !dis) |=> LASER_ON_O)
        else $error("laser not restored");
    a_init_no_fault: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (st_r == ST_INIT) |-> !TX_FAULT_OE_N_O)
        else $error("fault shown during init");

    // ------------------------------------------------------------
    // signal loss filter
    // ------------------------------------------------------------
    logic [31:0] loss_cnt_r;
    logic        absent_r, rxd_r;
    wire         loss_diff = (pwr_low != absent_r);
    wire         loss_flip = loss_diff && (loss_cnt_r >= LOSS_CYCLES - 8);
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            loss_cnt_r <= 32'h0000_0000;
            absent_r   <= 1'b1;
            rxd_r      <= 1'b0;
        end else begin
            loss_cnt_r <= (loss_diff && !loss_flip) ? inc32(loss_cnt_r) : 32'h0000_0000;
            if (loss_flip)
                absent_r <= pwr_low;
            rxd_r <= (absent_r || loss_flip && pwr_low) ? 1'b0 : rxd_s_r[1];
        end
    end
    assign RX_SIGNAL_ABSENT_O      = 1'b0;
    assign RX_SIGNAL_ABSENT_OE_N_O = absent_r;
    assign RX_DATA_O               = rxd_r;
    // presence pin always pulled to ground
    assign MODULE_PRESENT_N_O      = 1'b0;
    assign MODULE_PRESENT_N_OE_N_O = 1'b0;

    a_loss_bounded: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        loss_diff |-> loss_cnt_r < LOSS_CYCLES)
        else $error("loss filter overran");
    a_rx_data_low: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $past(absent_r) && absent_r |-> !RX_DATA_O)
        else $error("data not held low in loss");
    a_loss_filtered: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $changed(RX_SIGNAL_ABSENT_OE_N_O) |-> $past(loss_cnt_r) >= LOSS_CYCLES - 8)
        else $error("loss output flipped before filter span");

    // ------------------------------------------------------------
    // id two-wire slave, read-only byte memory
    // ------------------------------------------------------------
    // host keeps the clock at or under the limit; oversampling relies on it
    wire start_c = scl && scl_d_r && sda_d_r && !sda;
    wire stop_c  = scl && scl_d_r && !sda_d_r && sda;
    wire scl_up  = scl && !scl_d_r;
    wire scl_dn  = !scl && scl_d_r;

    pos_id_t     is_r;
    logic [2:0]  bit_r;
    logic [7:0]  sh_r, ptr_r;
    logic        rd_r, wr_ptr_r, sda_drv_r;
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            is_r      <= IS_IDLE;
            bit_r     <= 3'h0;
            sh_r      <= 8'h00;
            ptr_r     <= 8'h00;
            rd_r      <= 1'b0;
            wr_ptr_r  <= 1'b0;
            sda_drv_r <= 1'b0;
        end else if (start_c) begin
            is_r      <= IS_ADDR;
            bit_r     <= 3'h0;
            wr_ptr_r  <= 1'b0;
            sda_drv_r <= 1'b0;
        end else if (stop_c) begin
            is_r      <= IS_IDLE;
            sda_drv_r <= 1'b0;
        end else begin
            unique case (is_r)
                IS_IDLE: sda_drv_r <= 1'b0;
                IS_ADDR: if (scl_up) begin
                    sh_r  <= {sh_r[6:0], sda};
                    bit_r <= bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        if (sh_r[6:0] == ID_DEV_ADDR || wr_ptr_r) begin
                            is_r <= IS_ACK;
                            rd_r <= sda && !wr_ptr_r;
                            if (wr_ptr_r)
                                ptr_r <= {sh_r[6:0], sda};
                        end else begin
                            is_r <= IS_IDLE;
                        end
                    end
                end
                IS_ACK: begin
                    if (scl_dn && !sda_drv_r) begin
                        sda_drv_r <= 1'b1;
                    end else if (scl_dn) begin
                        wr_ptr_r  <= !rd_r && !wr_ptr_r;
                        is_r      <= rd_r ? IS_RD : IS_ADDR;
                        sh_r      <= ID_ROM_FILL;
                        sda_drv_r <= rd_r && !ID_ROM_FILL[7];
                    end
                end
                IS_RD: if (scl_dn) begin
                    bit_r     <= bit_r + 3'h1;
                    sh_r      <= {sh_r[6:0], 1'b0};
                    sda_drv_r <= (bit_r != 3'h7) && !sh_r[6];
                    if (bit_r == 3'h7) begin
                        is_r  <= IS_RACK;
                        ptr_r <= ptr_r + 8'h01;
                    end
                end
                // next byte starts at the end of the master ack clock
                IS_RACK: begin
                    if (scl_up && sda) begin
                        is_r <= IS_IDLE;
                    end else if (scl_dn) begin
                        is_r      <= IS_RD;
                        sh_r      <= ID_ROM_FILL;
                        sda_drv_r <= !ID_ROM_FILL[7];
                    end
                end
            endcase
        end
    end
    assign ID_SERIAL_DATA_O      = 1'b0;
    assign ID_SERIAL_DATA_OE_N_O = !sda_drv_r;

    a_id_idle_quiet: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (is_r == IS_IDLE && $past(is_r) == IS_IDLE) |-> ID_SERIAL_DATA_OE_N_O)
        else $error("data line driven while idle");
    a_id_foreign_quiet: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (is_r == IS_ADDR && scl_up && bit_r == 3'h7 && !wr_ptr_r && sh_r[6:0] != ID_DEV_ADDR)
        |=> (is_r == IS_IDLE && ID_SERIAL_DATA_OE_N_O))
        else $error("foreign address answered");
endmodule

`default_nettype wire
